// ===== verilog/umb_pkg.sv
// shared constants and types of the serial mode and baud generator block
// assumes one 20 MHz ref_clk and a simple byte-wide cpu register port
package umb_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [15:0] SYNC_MODE_ADDR  = 16'hff72;
  localparam logic [15:0] ASYNC_MODE_ADDR = 16'hffa0;
  localparam logic [15:0] BAUD_CTRL_ADDR  = 16'hffa1;
  localparam logic [15:0] DATA_ADDR       = 16'hffa2;
  localparam logic [15:0] RX_STATUS_ADDR  = 16'hffa3;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // ------------------------------------------------------------
  // baud control fields and limits
  // ------------------------------------------------------------
  localparam int          PS_MSB          = 6;
  localparam int          PS_LSB          = 4;
  localparam int          DV_MSB          = 3;
  localparam int          DV_LSB          = 0;
  localparam logic [9:0]  PRE_BASE        = 10'h004;
  localparam logic [9:0]  PRE_ONE         = 10'h001;
  localparam logic [4:0]  DIV_BASE        = 5'h0f;
  localparam logic [3:0]  DIV_PROHIBITED  = 4'hf;
  localparam logic [3:0]  DIV_MAX_CODE    = 4'he;

  // ------------------------------------------------------------
  // frame and buffer shape
  // ------------------------------------------------------------
  localparam int          DATA_W          = 8;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [2:0]  LAST_BIT_7      = 3'h6;
  localparam logic [2:0]  LAST_BIT_8      = 3'h7;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } umb_parity_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } umb_state_e;

  // async mode register, bit 7 down to bit 0
  typedef struct packed {
    logic        tx_en;
    logic        rx_en;
    umb_parity_e parity;
    logic        char8;
    logic        stop2;
    logic        err_sup;
    logic        rsvd;
  } umb_mode_s;

  // receive error status, bits 2 down to 0
  typedef struct packed {
    logic pe;
    logic fe;
    logic ove;
  } umb_err_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } umb_bus_s;

endpackage

// ===== verilog/umb_fifo.sv
// small synchronous fifo for transmit bytes
// assumes a single clock; pushes refused while full, pops while empty
`timescale 1ns/1ps
module umb_fifo #(
  parameter int WIDTH = umb_pkg::DATA_W,
  parameter int DEPTH = umb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import umb_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;

  wire            push  = in_valid && in_ready;
  wire            pop   = out_valid && out_ready;
  wire [AW:0]     level = wr_ptr_r - rd_ptr_r;

  assign in_ready  = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    level <= (AW+1)'(DEPTH)) else $error("fifo level beyond depth");

endmodule

// ===== verilog/umb_baud_gen.sv
// prescaler plus 5-bit divider producing a half-bit tick enable
// assumes clr held while the owning side is idle, so each frame restarts phase
`timescale 1ns/1ps
module umb_baud_gen (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // control
  input  wire logic       clr,
  input  wire logic [2:0] prescale,
  input  wire logic [3:0] divide,
  // tick out
  output logic            half_tick
);
  import umb_pkg::*;

  logic [8:0] pre_r;
  logic [4:0] div_r;

  // source clock is ref_clk over 2^(code+2)
  wire [9:0] pre_lim   = (PRE_BASE << prescale) - PRE_ONE;
  wire       fsck_tick = pre_r == pre_lim[8:0];
  // prohibited code runs as the largest legal one
  wire [3:0] div_code  = (divide == DIV_PROHIBITED) ? DIV_MAX_CODE : divide;
  wire [4:0] div_lim   = DIV_BASE + {1'b0, div_code};

  // two ticks per bit gives the extra factor of two in the bit rate
  // code 8'h24 at 20 MHz gives 640 clocks a bit, the 31.25 kbit/s rate
  assign half_tick = fsck_tick && (div_r == div_lim);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_r <= '0;
      div_r <= '0;
    end
    else if (clr || fsck_tick)
    begin
      pre_r <= '0;
      div_r <= (clr || half_tick) ? 5'h00 : div_r + 5'h01;
    end
    else
      pre_r <= pre_r + 9'h001;
  end

  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    half_tick |=> (!half_tick)[*8]) else $error("half ticks too close");

endmodule

// ===== verilog/umb_uart_top.sv
// asynchronous serial port: mode, status and baud registers, tx and rx framing
// assumes a byte-wide cpu port with one-cycle rd/wr strobes and sync pin inputs
//
// Summary of operation
// - one data byte follows each start bit; tx and rx run concurrently.
// - two top mode bits select disabled, rx only, tx only or full duplex.
// - parity field: none, forced zero without check, odd, even.
// - length bit picks 7 or 8 data bits; stop bit picks 1 or 2 stops.
// - receiver checks just one stop bit whatever the stop setting.
// - error suppress bit blocks the completion event for a bad frame.
// - status is read only: bit2 parity, bit1 framing, bit0 overrun.
// - framing flag sets when the stop position is not high.
// - overrun sets when a frame completes before the buffer was read.
// - overrun repeats on each frame until software reads the buffer.
// - prescale field divides the system clock by 2^(n+1), n = code+1.
// - divider field divides the source by 16+k; code 15 is prohibited.
// - bit rate equals system clock over 2^(n+2) times (k+16).
// - settings exist that reach 31.25 kbit/s.
// - reset clears baud control, mode and status registers.
// - buffer read or next completion clears status; new errors set again.
// - the error event comes before the completion event of a frame.
// - writing data with tx enabled starts a frame with framing bits added.
// - 7-bit mode drops tx bit 7 and returns rx bit 7 as zero.
`timescale 1ns/1ps
module umb_uart_top (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  // cpu register port
  input  wire umb_pkg::umb_bus_s bus,
  output logic [7:0]           rdata,
  output logic                 tx_space,
  // serial pins and pin function
  input  wire logic            serial_in_pin,
  output logic                 serial_out_pin,
  output logic                 rx_pin_serial,
  output logic                 tx_pin_serial,
  // events
  output logic                 receive_error_irq,
  output logic                 receive_done_irq
);
  import umb_pkg::*;

  // ------------------------------------------------------------
  // registers and decode
  // ------------------------------------------------------------
  logic [7:0] sync_mode_r;
  umb_mode_s  mode_r;
  logic [7:0] baud_r;
  umb_err_s   status_r;
  logic [7:0] rx_buf_r;
  logic       rx_full_r;
  logic [7:0] rdata_r;

  wire sel_sync   = bus.addr == SYNC_MODE_ADDR;
  wire sel_mode   = bus.addr == ASYNC_MODE_ADDR;
  wire sel_baud   = bus.addr == BAUD_CTRL_ADDR;
  wire sel_data   = bus.addr == DATA_ADDR;
  wire sel_status = bus.addr == RX_STATUS_ADDR;
  wire rx_rd      = bus.rd && sel_data;

  // unmapped addresses read as zero
  wire [7:0] rd_mux = sel_sync   ? sync_mode_r :
                      sel_mode   ? mode_r :
                      sel_baud   ? baud_r :
                      sel_data   ? rx_buf_r :
                      sel_status ? {5'h00, status_r} : 8'h00;

  assign rdata         = rdata_r;
  assign rx_pin_serial = mode_r.rx_en;
  assign tx_pin_serial = mode_r.tx_en;

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  umb_state_e tx_st_r;
  umb_state_e tx_st_nxt;
  logic [2:0] tx_cnt_r;
  logic [2:0] tx_cnt_nxt;
  logic       tx_out_r;
  logic       tx_out_nxt;
  logic       tx_two_r;
  logic       tx_two_nxt;
  logic       tx_phase_r;
  logic [7:0] tx_sh_r;
  logic       tx_tick;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  wire [2:0] last_idx = mode_r.char8 ? LAST_BIT_8 : LAST_BIT_7;
  // writes while tx is off, or while the fifo is full, are dropped
  wire       tx_push  = bus.wr && sel_data && mode_r.tx_en;
  wire       tx_pop   = (tx_st_r == ST_IDLE) && mode_r.tx_en && fifo_valid;
  wire       tx_adv   = tx_tick && tx_phase_r;
  wire [7:0] tx_word  = mode_r.char8 ? fifo_data : {1'b0, fifo_data[6:0]};
  wire       tx_par   = (mode_r.parity == PAR_ODD)  ? ~^tx_sh_r :
                        (mode_r.parity == PAR_EVEN) ?  ^tx_sh_r : 1'b0;

  assign serial_out_pin = tx_out_r;

  umb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (tx_push),
    .in_ready  (tx_space),
    .in_data   (bus.wdata),
    .out_valid (fifo_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_data)
  );

  umb_baud_gen u_tx_baud (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clr       (tx_st_r == ST_IDLE),
    .prescale  (baud_r[PS_MSB:PS_LSB]),
    .divide    (baud_r[DV_MSB:DV_LSB]),
    .half_tick (tx_tick)
  );

  always_comb
  begin
    tx_st_nxt  = tx_st_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_out_nxt = tx_out_r;
    tx_two_nxt = tx_two_r;
    unique case (tx_st_r)
      ST_IDLE:
        if (tx_pop)
        begin
          tx_st_nxt  = ST_START;
          tx_out_nxt = 1'b0;
          tx_cnt_nxt = 3'h0;
          tx_two_nxt = 1'b0;
        end
      ST_START:
        if (tx_adv)
        begin
          tx_st_nxt  = ST_DATA;
          tx_out_nxt = tx_sh_r[0];
        end
      ST_DATA:
        if (tx_adv && tx_cnt_r == last_idx)
        begin
          tx_st_nxt  = (mode_r.parity == PAR_NONE) ? ST_STOP : ST_PAR;
          tx_out_nxt = (mode_r.parity == PAR_NONE) ? 1'b1 : tx_par;
        end
        else if (tx_adv)
        begin
          tx_cnt_nxt = tx_cnt_r + 3'h1;
          tx_out_nxt = tx_sh_r[tx_cnt_r + 3'h1];
        end
      ST_PAR:
        if (tx_adv)
        begin
          tx_st_nxt  = ST_STOP;
          tx_out_nxt = 1'b1;
        end
      ST_STOP:
        if (tx_adv && mode_r.stop2 && !tx_two_r)
          tx_two_nxt = 1'b1;
        else if (tx_adv)
          tx_st_nxt = ST_IDLE;
      default:
        tx_st_nxt = ST_IDLE;
    endcase
    if (!mode_r.tx_en)
    begin
      tx_st_nxt  = ST_IDLE;
      tx_out_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  umb_state_e rx_st_r;
  umb_state_e rx_st_nxt;
  logic [2:0] rx_cnt_r;
  logic [2:0] rx_cnt_nxt;
  logic [7:0] rx_sh_r;
  logic       rx_par_r;
  logic       rx_phase_r;
  logic       rx_tick;
  logic       err_pend_r;
  logic       done_pend_r;
  logic       err_irq_r;
  logic       done_irq_r;

  wire rx_adv    = rx_tick && rx_phase_r;
  wire rx_done_p = (rx_st_r == ST_STOP) && rx_adv && mode_r.rx_en;
  wire par_x     = ^{rx_sh_r, rx_par_r};
  wire rx_pe     = ((mode_r.parity == PAR_ODD) && !par_x) ||
                   ((mode_r.parity == PAR_EVEN) && par_x);
  // one stop sample decides framing even with two stops set
  umb_err_s rx_err;
  assign rx_err.pe  = rx_pe;
  assign rx_err.fe  = !serial_in_pin;
  assign rx_err.ove = rx_full_r && !rx_rd;
  wire rx_bad = |rx_err;

  assign receive_error_irq = err_irq_r;
  assign receive_done_irq  = done_irq_r;

  umb_baud_gen u_rx_baud (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clr       (rx_st_r == ST_IDLE),
    .prescale  (baud_r[PS_MSB:PS_LSB]),
    .divide    (baud_r[DV_MSB:DV_LSB]),
    .half_tick (rx_tick)
  );

  always_comb
  begin
    rx_st_nxt  = rx_st_r;
    rx_cnt_nxt = rx_cnt_r;
    unique case (rx_st_r)
      ST_IDLE:
        if (!serial_in_pin)
          rx_st_nxt = ST_START;
      // half a bit in, the line must still be low or it was a glitch
      ST_START:
        if (rx_tick)
        begin
          rx_st_nxt  = serial_in_pin ? ST_IDLE : ST_DATA;
          rx_cnt_nxt = 3'h0;
        end
      ST_DATA:
        if (rx_adv && rx_cnt_r == last_idx)
          rx_st_nxt = (mode_r.parity == PAR_NONE) ? ST_STOP : ST_PAR;
        else if (rx_adv)
          rx_cnt_nxt = rx_cnt_r + 3'h1;
      ST_PAR:
        if (rx_adv)
          rx_st_nxt = ST_STOP;
      ST_STOP:
        if (rx_adv)
          rx_st_nxt = ST_IDLE;
      default:
        rx_st_nxt = ST_IDLE;
    endcase
    // dropping the enable aborts at once and leaves buffer and status alone
    if (!mode_r.rx_en)
      rx_st_nxt = ST_IDLE;
  end

  // ------------------------------------------------------------
  // sequential state
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_mode_r <= REG_RESET;
      mode_r      <= umb_mode_s'(REG_RESET);
      baud_r      <= REG_RESET;
      rdata_r     <= REG_RESET;
    end
    else
    begin
      if (bus.wr && sel_sync)
        sync_mode_r <= bus.wdata;
      if (bus.wr && sel_mode)
        mode_r <= umb_mode_s'(bus.wdata);
      if (bus.wr && sel_baud)
        baud_r <= bus.wdata;
      if (bus.rd)
        rdata_r <= rd_mux;
    end
  end

  // a completion in the same cycle as a buffer read wins over the clear
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_r  <= umb_err_s'(3'h0);
      rx_buf_r  <= REG_RESET;
      rx_full_r <= 1'b0;
    end
    else if (rx_done_p)
    begin
      status_r  <= rx_err;
      rx_buf_r  <= rx_sh_r;
      rx_full_r <= 1'b1;
    end
    else if (rx_rd)
    begin
      status_r  <= umb_err_s'(3'h0);
      rx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_st_r    <= ST_IDLE;
      tx_cnt_r   <= 3'h0;
      tx_out_r   <= 1'b1;
      tx_two_r   <= 1'b0;
      tx_phase_r <= 1'b0;
      tx_sh_r    <= 8'h00;
    end
    else
    begin
      tx_st_r    <= tx_st_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_out_r   <= tx_out_nxt;
      tx_two_r   <= tx_two_nxt;
      tx_phase_r <= (tx_st_r == ST_IDLE) ? 1'b0 : tx_phase_r ^ tx_tick;
      if (tx_pop)
        tx_sh_r <= tx_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_st_r    <= ST_IDLE;
      rx_cnt_r   <= 3'h0;
      rx_sh_r    <= 8'h00;
      rx_par_r   <= 1'b0;
      rx_phase_r <= 1'b0;
    end
    else
    begin
      rx_st_r    <= rx_st_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_phase_r <= (rx_st_r inside {ST_IDLE, ST_START}) ? 1'b0 : rx_phase_r ^ rx_tick;
      if (rx_st_r == ST_IDLE)
        rx_sh_r <= 8'h00;
      else if (rx_st_r == ST_DATA && rx_adv)
        rx_sh_r[rx_cnt_r] <= serial_in_pin;
      if (rx_st_r == ST_PAR && rx_adv)
        rx_par_r <= serial_in_pin;
    end
  end

  // error event first, completion one cycle later
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      err_irq_r   <= 1'b0;
      done_pend_r <= 1'b0;
      done_irq_r  <= 1'b0;
    end
    else
    begin
      err_irq_r   <= rx_done_p && rx_bad;
      done_pend_r <= rx_done_p && !(rx_bad && mode_r.err_sup);
      done_irq_r  <= done_pend_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  err_then_done_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    receive_error_irq && !mode_r.err_sup |=> receive_done_irq)
    else $error("completion did not follow error event");
  err_suppress_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    receive_error_irq && $past(mode_r.err_sup) |=> !receive_done_irq)
    else $error("completion raised for suppressed bad frame");
  status_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && sel_status |=> rdata == {5'h00, $past(status_r)})
    else $error("status read value wrong");
  overrun_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_done_p && rx_full_r && !rx_rd |=> status_r.ove && rx_full_r)
    else $error("overrun not flagged");
  read_clears_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_rd && !rx_done_p |=> status_r == 3'h0 && !rx_full_r)
    else $error("buffer read did not clear status");
  framing_err_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_done_p && !serial_in_pin |=> status_r.fe && receive_error_irq ##1 !receive_error_irq)
    else $error("framing error not flagged");
  seven_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rx_done_p && !mode_r.char8 |=> rx_buf_r[7] == 1'b0)
    else $error("bit 7 not zero in 7-bit mode");
  start_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    tx_pop |=> !serial_out_pin [*2])
    else $error("start bit not driven");
  tx_off_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !mode_r.tx_en |=> serial_out_pin && tx_st_r == ST_IDLE)
    else $error("tx active while disabled");

endmodule

// ===== test/umb_peer.sv
// serial partner model: shifts frames into the port, captures frames it sends
// assumes bit times in ref_clk cycles and frames built lsb first by the caller
`timescale 1ns/1ps
module umb_peer (
  // clock
  input  wire logic ref_clk,
  // serial lines
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  initial serial_in_pin = 1'b1;

  // drive n frame bits, then return the line to idle high
  task automatic send(input logic [11:0] f, input int n, input int bt);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      serial_in_pin <= f[i];
      repeat (bt) @(posedge ref_clk);
    end
    serial_in_pin <= 1'b1;
  endtask

  // sample at mid bit; returns at the last stop so back-to-back starts are seen
  task automatic grab(output logic [11:0] f, output logic to, input int n, input int bt);
    int w;
    f = 12'hfff;
    for (w = 0; w < 30000 && serial_out_pin !== 1'b0; w++)
    begin
      @(posedge ref_clk);
      #1;
    end
    to = (w == 30000);
    repeat (bt / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      #1 f[i] = serial_out_pin;
      if (i < n - 1)
        repeat (bt) @(posedge ref_clk);
    end
  endtask
endmodule

// ===== test/tb.sv
// self-checking bench: registers, pin function, frames, errors, baud, fifo
// assumes the register map of umb_pkg and a 20 MHz ref_clk
`timescale 1ns/1ps
module tb;
  import umb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  umb_bus_s    bus = '0;
  logic [7:0]  rdata, v;
  logic        tx_space, si, so, rxs, txs, eirq, dirq, to;
  logic [11:0] f, g;
  int          err_count = 0;
  int          total_checks = 0;
  int          nd = 0;
  int          ne = 0;
  int          n;
  time         td, te;

  always #25 ref_clk = ~ref_clk;

  umb_uart_top dut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .tx_space(tx_space), .serial_in_pin(si), .serial_out_pin(so),
    .rx_pin_serial(rxs), .tx_pin_serial(txs), .receive_error_irq(eirq),
    .receive_done_irq(dirq));
  umb_peer peer (.ref_clk(ref_clk), .serial_out_pin(so), .serial_in_pin(si));

  // irq pulses last one cycle, so count them and keep their times
  always @(posedge ref_clk)
  begin
    if (dirq === 1'b1)
    begin
      nd++;
      td = $time;
    end
    if (eirq === 1'b1)
    begin
      ne++;
      te = $time;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] frm(input logic [7:0] d, input logic [1:0] par,
                                      input logic c8, input logic s2, output int k);
    logic [7:0] dd;
    dd = c8 ? d : {1'b0, d[6:0]};
    frm = 12'hffe;
    k = 1;
    for (int i = 0; i < (c8 ? 8 : 7); i++)
    begin
      frm[k] = dd[i];
      k++;
    end
    if (par != 2'b00)
    begin
      frm[k] = (par == 2'b01) ? 1'b0 : (par == 2'b10) ? ~^dd : ^dd;
      k++;
    end
    k += s2 ? 2 : 1;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) bus <= '0;
    #1 d = rdata;
  endtask

  task automatic rxf(input logic [7:0] md, input logic [7:0] d, input logic [11:0] x,
                     input logic [7:0] st, input int dn, input int er);
    int n0, e0;
    n0 = nd;
    e0 = ne;
    g = frm(d, md[5:4], md[3], 1'b0, n);
    peer.send(g ^ x, n, 128);
    repeat (4) @(posedge ref_clk);
    chk(nd - n0, dn);
    chk(ne - e0, er);
    rd(RX_STATUS_ADDR, v);
    chk(v, st);
    if (dn > 0 && er > 0)
      chk(te < td, 1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [15:0] ra [5];
    ra = '{SYNC_MODE_ADDR, ASYNC_MODE_ADDR, BAUD_CTRL_ADDR, RX_STATUS_ADDR, 16'hff00};
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk(v, REG_RESET);
    end
    wr(SYNC_MODE_ADDR, 8'h00);
    wr(RX_STATUS_ADDR, 8'h07);
    rd(RX_STATUS_ADDR, v);
    chk(v, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(ASYNC_MODE_ADDR, {m[1:0], 6'h0c});
      rd(ASYNC_MODE_ADDR, v);
      chk(v, {m[1:0], 6'h0c});
      chk({txs, rxs}, m[1:0]);
    end
    wr(ASYNC_MODE_ADDR, 8'h00);
    $display("regs done");
  endtask

  task automatic t_tx();
    logic [1:0] par;
    wr(BAUD_CTRL_ADDR, 8'h00);
    for (int pm = 0; pm < 5; pm++)
    begin
      par = (pm < 4) ? pm[1:0] : 2'b00;
      g = frm(8'hd3, par, pm < 4, pm[0], n);
      wr(ASYNC_MODE_ADDR, {2'b10, par, pm < 4, pm[0], 2'b00});
      fork
        peer.grab(f, to, n, 128);
        wr(DATA_ADDR, 8'hd3);
      join
      chk({3'b0, to, f}, {4'h0, g});
      repeat (256) @(posedge ref_clk);
    end
    $display("tx done");
  endtask

  task automatic t_baud();
    wr(ASYNC_MODE_ADDR, 8'h00);
    wr(BAUD_CTRL_ADDR, 8'h24);
    wr(ASYNC_MODE_ADDR, 8'h88);
    g = frm(8'h96, 2'b00, 1'b1, 1'b0, n);
    fork
      peer.grab(f, to, n, 640);
      wr(DATA_ADDR, 8'h96);
    join
    chk({3'b0, to, f}, {4'h0, g});
    repeat (640) @(posedge ref_clk);
    wr(ASYNC_MODE_ADDR, 8'h00);
    wr(BAUD_CTRL_ADDR, 8'h00);
    $display("baud done");
  endtask

  task automatic t_rx();
    wr(ASYNC_MODE_ADDR, 8'h78);
    rxf(8'h78, 8'h5a, 12'h000, 8'h00, 1, 0);
    rd(DATA_ADDR, v);
    chk(v, 8'h5a);
    rxf(8'h78, 8'h33, 12'h200, 8'h04, 1, 1);
    rd(DATA_ADDR, v);
    rd(RX_STATUS_ADDR, v);
    chk(v, 8'h00);
    rxf(8'h78, 8'h0f, 12'h400, 8'h02, 1, 1);
    rxf(8'h78, 8'h11, 12'h000, 8'h01, 1, 1);
    rxf(8'h78, 8'h22, 12'h000, 8'h01, 1, 1);
    rd(DATA_ADDR, v);
    chk(v, 8'h22);
    wr(ASYNC_MODE_ADDR, 8'h7c);
    rxf(8'h7c, 8'h66, 12'h000, 8'h00, 1, 0);
    rd(DATA_ADDR, v);
    chk(v, 8'h66);
    wr(ASYNC_MODE_ADDR, 8'h7a);
    rxf(8'h7a, 8'h44, 12'h200, 8'h04, 0, 1);
    rd(DATA_ADDR, v);
    wr(ASYNC_MODE_ADDR, 8'h68);
    rxf(8'h68, 8'h44, 12'h000, 8'h00, 1, 0);
    rd(DATA_ADDR, v);
    wr(ASYNC_MODE_ADDR, 8'h40);
    rxf(8'h40, 8'hff, 12'h000, 8'h00, 1, 0);
    rd(DATA_ADDR, v);
    chk(v, 8'h7f);
    wr(ASYNC_MODE_ADDR, 8'h58);
    rxf(8'h58, 8'h01, 12'h200, 8'h00, 1, 0);
    wr(ASYNC_MODE_ADDR, 8'h00);
    $display("rx done");
  endtask

  task automatic t_fifo();
    int c;
    wr(ASYNC_MODE_ADDR, 8'h88);
    fork
      begin
        for (c = 0; c < 12 && tx_space === 1'b1; c++)
          wr(DATA_ADDR, 8'(c));
        chk(c, FIFO_DEPTH + 1);
        wr(DATA_ADDR, 8'hee);
      end
      for (int i = 0; i <= FIFO_DEPTH; i++)
      begin
        peer.grab(f, to, 10, 128);
        chk({3'b0, to, f}, {4'h0, frm(8'(i), 2'b00, 1'b1, 1'b0, n)});
      end
    join
    chk(tx_space, 1'b1);
    // a tenth frame would be in its start bit by now if the refused byte got in
    repeat (130) @(posedge ref_clk);
    chk(so, 1'b1);
    $display("fifo done");
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_tx();
    t_baud();
    t_rx();
    t_fifo();
    give_verdict();
  end

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
endmodule
